// *** rtl/mic_map.vh ***
// Register offsets, field positions, reset values and vectors of the
// interrupt controller. Assumes word-aligned AHB-Lite access.
//
// Behaviour
// RL1 - Accept eight latched event sources
// RL2 - Global enable gates every unmasked source
// RL3 - Per-source enables writable regardless of global
// RL4 - Taken request clears global, vectors to 001h
// RL5 - Software clears flags before re-enabling global
// RL6 - Enable instruction sets, disable clears global
// RL7 - Return-from-handler sets global enable again
// RL8 - Flags set regardless of their enable
// RL9 - Flag read returns flags AND enables
// RL10 - Software interrupt instruction vectors to 002h
// RL11 - External pin edge polarity is selectable
// RL12 - External edge sets flag 1, enable 1
// RL13 - Enabled external edge wakes sleeping core
// RL14 - Timer 0 rollover sets flag 0
// RL15 - Timer 1 match sets flag 3, status 4
// RL16 - Flag 3 clears only after status 4
// RL17 - Timer 2 or 16-bit match sets flag 4
// RL18 - Timer 3 flag 5, never in 16-bit
// RL19 - SPI byte done sets flag 2, status 1
// RL20 - SPI byte start sets flag 7, status 6
// RL21 - Conversion done sets flag 6
// RL22 - Second falling edge ends conversion, clears enable
// RL23 - Flags sticky; hardware set beats software clear
// RL24 - All hardware sources share one vector
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// Register byte offsets
`define MIC_OFF_FLAGS 8'h00
`define MIC_OFF_ENABLES 8'h04
`define MIC_OFF_OPTION 8'h08
`define MIC_OFF_MODE 8'h0C
`define MIC_OFF_SERIAL 8'h10
`define MIC_OFF_CONV 8'h14
`define MIC_OFF_CORE 8'h18

// Flag and enable bit positions
`define MIC_SRC_T0 0
`define MIC_SRC_EXT 1
`define MIC_SRC_RX 2
`define MIC_SRC_T1 3
`define MIC_SRC_T2 4
`define MIC_SRC_T3 5
`define MIC_SRC_CONV 6
`define MIC_SRC_TX 7

// Option, mode, serial status, converter and core status fields
`define MIC_BIT_GLOBAL 6
`define MIC_BIT_EDGE 0
`define MIC_BIT_MODE16 1
`define MIC_BIT_RXSTAT 1
`define MIC_BIT_T1STAT 4
`define MIC_BIT_TXSTAT 6
`define MIC_BIT_CONVEN 7
`define MIC_BIT_VREQ 0
`define MIC_BIT_CACT 1

// Reset values and vectors
`define MIC_RST_BYTE 8'h00
`define MIC_RST_WORD 32'h00000000
`define MIC_RST_VEC 12'h000
`define MIC_VEC_HW 12'h001
`define MIC_VEC_SW 12'h002

`endif

// *** rtl/mic_edge_detect.v ***
// External pin edge detector with selectable polarity.
// Assumes the pin is already synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none

module mic_edge_detect (
	input wire hclk,
	input wire hresetn,
	input wire pin,
	input wire rising_sel,
	output reg edge_pulse
);

	reg prev_r;
	reg armed_r;

	// First sample after reset only arms, so a high pin is no false edge
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prev_r <= 1'b0;
			armed_r <= 1'b0;
			edge_pulse <= 1'b0;
		end
		else
		begin
			prev_r <= pin;
			armed_r <= 1'b1;
			edge_pulse <= armed_r & (rising_sel ? (pin & ~prev_r)
				: (~pin & prev_r)); // [RL11]
		end
	end

endmodule // mic_edge_detect

`default_nettype wire

// *** rtl/mic_conv_done.v ***
// Conversion end detector on the oscillation input.
// Assumes the input is synchronous to hclk; enable comes from software.
`timescale 1ns/10ps
`default_nettype none

module mic_conv_done (
	input wire hclk,
	input wire hresetn,
	input wire enable,
	input wire osc_in,
	output reg done_pulse,
	output reg active
);

	reg prev_r;
	reg armed_r;
	reg [1:0] falls_r;
	wire rise;
	wire fall;

	assign rise = armed_r & osc_in & ~prev_r;
	assign fall = armed_r & ~osc_in & prev_r;

	// Window opens on first rising edge; second falling edge ends it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prev_r <= 1'b0;
			armed_r <= 1'b0;
			falls_r <= 2'h0;
			active <= 1'b0;
			done_pulse <= 1'b0;
		end
		else if (!enable)
		begin
			prev_r <= osc_in;
			armed_r <= 1'b0;
			falls_r <= 2'h0;
			active <= 1'b0;
			done_pulse <= 1'b0;
		end
		else
		begin
			prev_r <= osc_in;
			armed_r <= 1'b1;
			done_pulse <= 1'b0;
			if (rise && !active && falls_r == 2'h0)
				active <= 1'b1;
			if (active && fall)
			begin
				falls_r <= falls_r + 2'h1;
				if (falls_r == 2'h1)
				begin
					done_pulse <= 1'b1; // [RL22]
					active <= 1'b0;
				end
			end
		end
	end

endmodule // mic_conv_done

`default_nettype wire

// *** rtl/mic_top.v ***
// Interrupt controller: latched event flags, enables, global enable,
// vector requests to the core fetch logic, AHB-Lite register slave.
// Assumes event strobes are one-cycle pulses synchronous to hclk and
// that the core pulses the instruction inputs once per execution.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mic_map.vh"

module mic_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire timer0_overflow_evt,
	input wire timer1_match_evt,
	input wire timer2_match_evt,
	input wire timer3_match_evt,
	input wire timer16_match_evt,
	input wire spi_rx_done_evt,
	input wire spi_tx_start_evt,
	input wire ext_pin,
	input wire oscillation_input,
	input wire enable_interrupts_instr,
	input wire disable_interrupts_instr,
	input wire return_from_handler_instr,
	input wire software_interrupt_instr,
	input wire core_sleeping,
	input wire vector_ack,
	output reg vector_req,
	output reg [11:0] vector_addr,
	output reg wake_pulse,
	output wire converter_enable
);

	// Keep set bits, drop cleared ones; a set in the same cycle wins
	function [7:0] mic_sticky;
		input [7:0] cur;
		input [7:0] set;
		input [7:0] clr;
		begin
			mic_sticky = (cur & ~clr) | set;
		end
	endfunction

	// Register word select; shared by write strobes and the read mux
	function mic_hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			mic_hit = (addr == off);
		end
	endfunction

	reg [7:0] interrupt_flags_r;
	reg [7:0] interrupt_flags_nxt;
	reg [7:0] interrupt_enables_r;
	reg [7:0] serial_status_r;
	reg [7:0] serial_status_nxt;
	reg global_enable_r;
	reg global_enable_nxt;
	reg ext_edge_select_r;
	reg mode16_r;
	reg converter_enable_r;
	reg wr_pend_r;
	reg rd_pend_r;
	reg [7:0] addr_r;
	reg [7:0] flag_set;
	reg [7:0] flag_clr;
	reg [7:0] stat_set;
	reg [7:0] stat_clr;
	reg [31:0] rd_mux;
	wire addr_take;
	wire ext_evt;
	wire conv_evt;
	wire conv_active;
	wire hw_take;
	wire [7:0] wbyte;
	wire wr_flags;
	wire wr_enables;
	wire wr_option;
	wire wr_mode;
	wire wr_serial;
	wire wr_conv;

	assign wbyte = hwdata[7:0];
	assign converter_enable = converter_enable_r;

	// Zero-wait writes, one wait state on reads so data comes from a flop
	assign hreadyout = ~rd_pend_r;
	assign hresp = 1'b0;
	assign addr_take = hsel & htrans[1] & hready;

	// Write strobes act in the data phase, while hwdata stands
	assign wr_flags = wr_pend_r & mic_hit(addr_r, `MIC_OFF_FLAGS);
	assign wr_enables = wr_pend_r & mic_hit(addr_r, `MIC_OFF_ENABLES);
	assign wr_option = wr_pend_r & mic_hit(addr_r, `MIC_OFF_OPTION);
	assign wr_mode = wr_pend_r & mic_hit(addr_r, `MIC_OFF_MODE);
	assign wr_serial = wr_pend_r & mic_hit(addr_r, `MIC_OFF_SERIAL);
	assign wr_conv = wr_pend_r & mic_hit(addr_r, `MIC_OFF_CONV);

	// Pin edge detector; a polarity change alone never makes an edge
	mic_edge_detect u_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(ext_pin),
		.rising_sel(ext_edge_select_r),
		.edge_pulse(ext_evt)
	);

	// Conversion window on the oscillation input; idle while disabled
	mic_conv_done u_conv (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(converter_enable_r),
		.osc_in(oscillation_input),
		.done_pulse(conv_evt),
		.active(conv_active)
	);

	// Event sources onto their flag bits
	always @*
	begin
		flag_set = `MIC_RST_BYTE; // [RL1]
		flag_set[`MIC_SRC_T0] = timer0_overflow_evt; // [RL14]
		flag_set[`MIC_SRC_EXT] = ext_evt; // [RL12]
		flag_set[`MIC_SRC_RX] = spi_rx_done_evt; // [RL19]
		flag_set[`MIC_SRC_T1] = timer1_match_evt; // [RL15]
		flag_set[`MIC_SRC_T2] = mode16_r ? timer16_match_evt
			: timer2_match_evt; // [RL17]
		// Timer 3 stays silent in 16-bit mode; its match is the wide one
		flag_set[`MIC_SRC_T3] = ~mode16_r & timer3_match_evt; // [RL18]
		flag_set[`MIC_SRC_CONV] = conv_evt; // [RL21]
		flag_set[`MIC_SRC_TX] = spi_tx_start_evt; // [RL20]
	end

	// Companion status bits in the serial status register
	always @*
	begin
		stat_set = `MIC_RST_BYTE;
		stat_set[`MIC_BIT_RXSTAT] = spi_rx_done_evt; // [RL19]
		stat_set[`MIC_BIT_T1STAT] = timer1_match_evt; // [RL15]
		stat_set[`MIC_BIT_TXSTAT] = spi_tx_start_evt; // [RL20]
	end

	// Software clears by writing zero; paired flags need status clear
	always @*
	begin
		flag_clr = `MIC_RST_BYTE;
		stat_clr = `MIC_RST_BYTE;
		if (wr_flags)
		begin
			flag_clr = ~wbyte; // [RL23]
			if (serial_status_r[`MIC_BIT_T1STAT])
				flag_clr[`MIC_SRC_T1] = 1'b0; // [RL16]
			if (serial_status_r[`MIC_BIT_RXSTAT])
				flag_clr[`MIC_SRC_RX] = 1'b0; // [RL19]
			if (serial_status_r[`MIC_BIT_TXSTAT])
				flag_clr[`MIC_SRC_TX] = 1'b0; // [RL20]
		end
		if (wr_serial)
		begin
			stat_clr[`MIC_BIT_RXSTAT] = ~wbyte[`MIC_BIT_RXSTAT];
			stat_clr[`MIC_BIT_T1STAT] = ~wbyte[`MIC_BIT_T1STAT];
			stat_clr[`MIC_BIT_TXSTAT] = ~wbyte[`MIC_BIT_TXSTAT];
		end
		interrupt_flags_nxt = mic_sticky(interrupt_flags_r, flag_set,
			flag_clr); // [RL8] [RL23]
		serial_status_nxt = mic_sticky(serial_status_r, stat_set,
			stat_clr);
	end

	// Any unmasked flag under global enable takes the shared vector.
	// A software request that cycle goes first; the flag stays pending
	// and is taken once the software vector has been acknowledged.
	assign hw_take = ~vector_req & ~software_interrupt_instr
		& global_enable_r
		& (|(interrupt_flags_r & interrupt_enables_r)); // [RL2] [RL24]

	// Global enable: hardware take beats instructions beats register write
	always @*
	begin
		global_enable_nxt = global_enable_r;
		if (wr_option)
			global_enable_nxt = wbyte[`MIC_BIT_GLOBAL];
		if (enable_interrupts_instr)
			global_enable_nxt = 1'b1; // [RL6]
		if (return_from_handler_instr)
			global_enable_nxt = 1'b1; // [RL7]
		if (disable_interrupts_instr)
			global_enable_nxt = 1'b0; // [RL6]
		if (hw_take)
			global_enable_nxt = 1'b0; // [RL4]
	end

	// Flag, status and global enable storage
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			interrupt_flags_r <= `MIC_RST_BYTE;
			serial_status_r <= `MIC_RST_BYTE;
			global_enable_r <= 1'b0;
		end
		else
		begin
			interrupt_flags_r <= interrupt_flags_nxt;
			serial_status_r <= serial_status_nxt;
			global_enable_r <= global_enable_nxt;
		end
	end

	// Plain control registers written over the bus
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			interrupt_enables_r <= `MIC_RST_BYTE;
			ext_edge_select_r <= 1'b0;
			mode16_r <= 1'b0;
			converter_enable_r <= 1'b0;
		end
		else
		begin
			if (wr_enables)
				interrupt_enables_r <= wbyte; // [RL3]
			// Mode bits only steer later events, never stored flags
			if (wr_mode)
			begin
				ext_edge_select_r <= wbyte[`MIC_BIT_EDGE]; // [RL11]
				mode16_r <= wbyte[`MIC_BIT_MODE16];
			end
			// Hardware end of conversion wins over a same-cycle write
			if (conv_evt)
				converter_enable_r <= 1'b0; // [RL22]
			else if (wr_conv)
				converter_enable_r <= wbyte[`MIC_BIT_CONVEN];
		end
	end

	// Vector request held until the fetch logic acknowledges it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vector_req <= 1'b0;
			vector_addr <= `MIC_RST_VEC;
		end
		// Requests arriving while one is pending are not queued
		else if (vector_req)
		begin
			if (vector_ack)
				vector_req <= 1'b0;
		end
		else if (software_interrupt_instr)
		begin
			vector_req <= 1'b1;
			vector_addr <= `MIC_VEC_SW; // [RL10]
		end
		else if (hw_take)
		begin
			vector_req <= 1'b1;
			vector_addr <= `MIC_VEC_HW; // [RL4]
		end
	end

	// Wake only resumes the core; the vector path decides handler or not
	// Enable bit 1 is read live, so software sets it before sleeping
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_pulse <= 1'b0;
		else
			wake_pulse <= core_sleeping & ext_evt
				& interrupt_enables_r[`MIC_SRC_EXT]; // [RL13]
	end

	// Read mux; unmapped offsets read zero
	always @*
	begin
		rd_mux = `MIC_RST_WORD;
		if (mic_hit(addr_r, `MIC_OFF_FLAGS))
			rd_mux[7:0] = interrupt_flags_r & interrupt_enables_r; // [RL9]
		else if (mic_hit(addr_r, `MIC_OFF_ENABLES))
			rd_mux[7:0] = interrupt_enables_r;
		else if (mic_hit(addr_r, `MIC_OFF_OPTION))
			rd_mux[`MIC_BIT_GLOBAL] = global_enable_r;
		else if (mic_hit(addr_r, `MIC_OFF_MODE))
		begin
			rd_mux[`MIC_BIT_EDGE] = ext_edge_select_r;
			rd_mux[`MIC_BIT_MODE16] = mode16_r;
		end
		else if (mic_hit(addr_r, `MIC_OFF_SERIAL))
			rd_mux[7:0] = serial_status_r;
		else if (mic_hit(addr_r, `MIC_OFF_CONV))
			rd_mux[`MIC_BIT_CONVEN] = converter_enable_r;
		else if (mic_hit(addr_r, `MIC_OFF_CORE))
		begin
			rd_mux[`MIC_BIT_VREQ] = vector_req;
			rd_mux[`MIC_BIT_CACT] = conv_active;
		end
	end

	// Bus phases: capture address, then write or fetch read data
	// A read wait blocks address capture; hready is low meanwhile
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= `MIC_RST_BYTE;
			hrdata <= `MIC_RST_WORD;
		end
		else
		begin
			if (rd_pend_r)
			begin
				hrdata <= rd_mux;
				rd_pend_r <= 1'b0;
			end
			else if (addr_take)
			begin
				addr_r <= {haddr[7:2], 2'b00};
				wr_pend_r <= hwrite;
				rd_pend_r <= ~hwrite;
			end
			else
				wr_pend_r <= 1'b0;
		end
	end

endmodule // mic_top

`default_nettype wire

// *** test/mic_checker.sv ***
// Concurrent checks on the interrupt controller top-level ports.
// Assumes a single hclk domain with asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module mic_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic software_interrupt_instr,
	input wire logic disable_interrupts_instr,
	input wire logic core_sleeping,
	input wire logic vector_ack,
	input wire logic vector_req,
	input wire logic [11:0] vector_addr,
	input wire logic wake_pulse
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_req_held: assert property (vector_req && !vector_ack
		|=> vector_req && $stable(vector_addr))
		else $error("vector request changed before ack");
	chk_req_drop: assert property (vector_req && vector_ack
		|=> !vector_req)
		else $error("vector request held after ack");
	chk_swi_vec: assert property (software_interrupt_instr
		&& !vector_req |=> vector_req && vector_addr == 12'h002)
		else $error("software vector not requested");
	chk_swi_cause: assert property ($rose(vector_req)
		&& vector_addr == 12'h002 |-> $past(software_interrupt_instr))
		else $error("software vector without instruction");
	chk_hw_vec: assert property ($rose(vector_req)
		&& !$past(software_interrupt_instr) |-> vector_addr == 12'h001)
		else $error("hardware request on wrong vector");
	chk_dis_block: assert property (disable_interrupts_instr
		##1 !software_interrupt_instr |=> !$rose(vector_req))
		else $error("request taken after disable");
	chk_wake_once: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse longer than one cycle");
	chk_wake_sleep: assert property (wake_pulse
		|-> $past(core_sleeping))
		else $error("wake pulse while core awake");
	chk_rd_wait: assert property (hsel && htrans[1] && hready
		&& !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
endmodule // mic_checker

bind mic_top mic_checker chk_i (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.software_interrupt_instr(software_interrupt_instr),
	.disable_interrupts_instr(disable_interrupts_instr),
	.core_sleeping(core_sleeping),
	.vector_ack(vector_ack),
	.vector_req(vector_req),
	.vector_addr(vector_addr),
	.wake_pulse(wake_pulse)
);
`default_nettype wire

// *** test/mic_fetch_model.sv ***
// Core fetch logic model: takes the vector after a chosen wait.
// Assumes vector_req is a level held until acknowledged.
`timescale 1ns/10ps
`default_nettype none

module mic_fetch_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic vector_req,
	input wire logic [1:0] dly,
	output logic vector_ack
);
	logic [1:0] cnt_r;

	// Single-cycle ack, so a dropping request is never acked twice
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= 2'h0;
			vector_ack <= 1'b0;
		end
		else
		begin
			vector_ack <= vector_req && !vector_ack && cnt_r == dly;
			cnt_r <= (vector_req && !vector_ack && cnt_r != dly)
				? cnt_r + 2'h1 : 2'h0;
		end
	end
endmodule // mic_fetch_model
`default_nettype wire

// *** test/tb_mcu_interrupt_controller.sv ***
// Self-checking bench for mic_top with queued expected results.
// Assumes AHB-Lite single slave; the fetch model acks vectors.
`timescale 1ns/10ps
`default_nettype none

module tb_mcu_interrupt_controller;
	logic hclk, hresetn, hsel, hwrite, ext_pin, osc, core_sleeping;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans, dly;
	logic [2:0] hsize;
	logic [10:0] pv;
	wire logic hready, hreadyout, hresp, vector_req, vector_ack;
	wire logic wake_pulse, converter_enable;
	wire logic [31:0] hrdata;
	wire logic [11:0] vector_addr;
	int err_total, tests_run, cyc;
	logic rd_ph, vr_d, w;
	logic [31:0] rq[$], vq[$];
	logic [31:0] ev;
	logic [7:0] r;

	assign hready = hreadyout;

	mic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .timer0_overflow_evt(pv[0]),
		.timer1_match_evt(pv[1]), .timer2_match_evt(pv[2]),
		.timer3_match_evt(pv[3]), .timer16_match_evt(pv[4]),
		.spi_rx_done_evt(pv[5]), .spi_tx_start_evt(pv[6]),
		.ext_pin(ext_pin), .oscillation_input(osc),
		.enable_interrupts_instr(pv[7]), .disable_interrupts_instr(pv[8]),
		.return_from_handler_instr(pv[9]),
		.software_interrupt_instr(pv[10]), .core_sleeping(core_sleeping),
		.vector_ack(vector_ack), .vector_req(vector_req),
		.vector_addr(vector_addr), .wake_pulse(wake_pulse),
		.converter_enable(converter_enable));

	mic_fetch_model fetch (.hclk(hclk), .hresetn(hresetn),
		.vector_req(vector_req), .dly(dly), .vector_ack(vector_ack));

	// 50 MHz clock
	always #10 hclk = ~hclk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask

	task print_verdict;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Single word transfer; a read notes its expected data
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr) rq.push_back(e);
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
	endtask

	task pls(input logic [10:0] m);
		pv <= m;
		@(posedge hclk);
		pv <= 11'h000;
		@(posedge hclk);
	endtask

	// Watcher: read data and new vectors against the oldest notes
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			err_total++;
			print_verdict;
		end
		if (rd_ph && hready)
		begin
			chk("hrdata", rq.pop_front(), hrdata);
			chk("hresp", 0, {31'h0, hresp});
		end
		if (hready) rd_ph = hsel && htrans[1] && !hwrite;
		if (vector_req === 1'b1 && !vr_d)
		begin
			ev = vq.size() ? vq.pop_front() : 32'hFFFF;
			chk("vector_addr", ev, {20'h0, vector_addr});
		end
		vr_d = vector_req;
	end

	initial
	begin
		{hclk, hresetn, hsel, hwrite, ext_pin, osc, core_sleeping} = 7'h00;
		{haddr, hwdata, htrans, dly, pv} = 0;
		hsize = 3'h2;
		{err_total, tests_run, cyc, rd_ph, vr_d} = 0;
		void'($urandom(14692));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++) bus(0, 8'(i * 4), 0, 0);
		r = 8'($urandom);
		bus(1, 8'h04, {24'h0, r}, 0);
		pls(11'h06F);
		bus(0, 8'h00, 0, {24'h0, r & 8'hBD});
		bus(0, 8'h10, 0, 32'h52);
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h04, 32'hFF, 0);
		bus(0, 8'h00, 0, 32'h8C);
		bus(1, 8'h10, 0, 0);
		bus(1, 8'h00, 0, 0);
		bus(0, 8'h00, 0, 0);
		// Each edge polarity under each select setting
		for (int k = 0; k < 4; k++)
		begin
			bus(1, 8'h0C, k < 2, 0);
			ext_pin <= ~k[0];
			repeat (4) @(posedge hclk);
			bus(0, 8'h00, 0, (k == 0 || k == 3) ? 2 : 0);
			bus(1, 8'h00, 0, 0);
		end
		bus(1, 8'h0C, 2, 0);
		pls(11'h018);
		bus(0, 8'h00, 0, 32'h10);
		bus(1, 8'h00, 0, 0);
		dly <= 2'($urandom);
		pls(11'h001);
		vq.push_back(1);
		pls(11'h080);
		repeat (12) @(posedge hclk);
		bus(0, 8'h08, 0, 0);
		bus(1, 8'h00, 0, 0);
		pls(11'h200);
		bus(0, 8'h08, 0, 32'h40);
		pls(11'h100);
		bus(0, 8'h08, 0, 0);
		vq.push_back(2);
		pls(11'h400);
		repeat (12) @(posedge hclk);
		bus(1, 8'h08, 32'h40, 0);
		vq.push_back(1);
		pls(11'h001);
		repeat (12) @(posedge hclk);
		bus(1, 8'h00, 0, 0);
		core_sleeping <= 1'b1;
		ext_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		ext_pin <= 1'b0;
		w = 0;
		repeat (6) @(posedge hclk) w |= wake_pulse;
		chk("wake_pulse", 1, {31'h0, w});
		core_sleeping <= 1'b0;
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h14, 32'h80, 0);
		bus(0, 8'h14, 0, 32'h80);
		chk("converter_enable", 1, {31'h0, converter_enable});
		// Window opens on the first rise; seen in core status
		osc <= 1'b1;
		repeat (3) @(posedge hclk);
		bus(0, 8'h18, 0, 32'h02);
		// Third pulse lands after the converter has already stopped
		repeat (2)
		begin
			osc <= 1'b0;
			repeat (3) @(posedge hclk);
			osc <= 1'b1;
			repeat (3) @(posedge hclk);
		end
		osc <= 1'b0;
		repeat (3) @(posedge hclk);
		bus(0, 8'h14, 0, 0);
		chk("converter_enable", 0, {31'h0, converter_enable});
		bus(0, 8'h00, 0, 32'h40);
		chk("vectors_left", 0, vq.size());
		print_verdict;
	end
endmodule // tb_mcu_interrupt_controller
`default_nettype wire
